// file: design/mmc_ctrl.v
`timescale 1ns/1ps
`include "mmc_defs.vh"

// Summary of operation
// - Position request: immediate reply, later arrival reply
// - Position request works in direct and download mode
// - Type 0 one move, type 1 every move
// - Immediate reply: status 100, opcode, mask
// - Arrival reply: addresses 02/01, status 128
// - Control opcodes never stored in program
// - Stop opcode halts the program
// - Run from current or given address
// - Step runs exactly one instruction
// - Program reset stops the program and pulses clear; memory is kept
// - Download stores later commands from address
// - Exit download resumes normal execution
// - Read memory returns stored location
// - Status type selects mode, pc, accu, index
// - Version as string or binary
// - Factory restore needs 1234, no reply
// - Software reset needs 1234, no reply
module mmc_ctrl #(
	parameter [55:0] VER_STR = 56'h4d4d4330303031, // Arbitrary version text
	parameter [31:0] VER_BIN = 32'h00010001         // Arbitrary version number
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        resetn_i,
	// Command bytes in
	input  wire [7:0]  rx_byte_i,
	input  wire        rx_valid_i,
	// Reply bytes out
	output wire [7:0]  tx_byte_o,
	output wire        tx_valid_o,
	input  wire        tx_ready_i,
	// Commands handed to the motion side
	output reg         fwd_valid_o,
	output reg  [7:0]  fwd_op_o,
	output reg  [7:0]  fwd_type_o,
	output reg  [7:0]  fwd_bank_o,
	output reg  [31:0] fwd_value_o,
	input  wire        fwd_done_i,
	input  wire [7:0]  fwd_status_i,
	input  wire [31:0] fwd_value_i,
	// Motion events
	input  wire        move_to_position_cmd_i,
	input  wire        pos_reached_i,
	// Program engine control
	output reg         prog_run_o,
	output reg         prog_step_o,
	output reg         prog_jump_o,
	output reg  [15:0] prog_addr_o,
	output reg         prog_clear_o,
	input  wire [15:0] eng_pc_i,
	input  wire        eng_wait_i,
	input  wire [31:0] eng_acc_i,
	input  wire [31:0] eng_x_i,
	input  wire        eng_step_done_i,
	// Program memory read port for the engine
	input  wire [7:0]  mem_rd_addr_i,
	output reg  [55:0] mem_rd_data_o,
	// System actions
	output reg         download_o,
	output reg         factory_restore_o,
	output reg         sw_reset_o
);

	// Main states
	localparam [1:0] S_IDLE = 2'h0; // Waiting for a frame
	localparam [1:0] S_FWD  = 2'h1; // Waiting for the motion side
	localparam [1:0] S_SEND = 2'h2; // Reply leaving

	// Reset synchroniser
	reg        rst_a_q;
	reg        rst_n_q;

	// Frame from the receiver
	wire        frm_valid;
	wire        frm_ok;
	wire [63:0] frm;
	wire [7:0]  f_addr;
	wire [7:0]  f_op;
	wire [7:0]  f_type;
	wire [31:0] f_val;

	// Reply path
	reg         tx_load_q;
	reg  [63:0] tx_data_q;
	wire        tx_busy;

	// Control state
	reg  [1:0]  state_q;
	reg  [7:0]  mode_q;      // Program mode for status
	reg  [7:0]  memptr_q;    // Download write pointer
	reg         arm_q;       // Position reply requested
	reg         persist_q;   // Request covers every move
	reg  [7:0]  mask_q;      // Motor bit mask
	reg         pend_q;      // A move awaits arrival
	reg         evt_q;       // Arrival reply owed
	wire        evt_set;     // Arrival accepted this cycle

	// Program memory: opcode, type, bank, value
	reg  [55:0] mem [0:(1<<`MMC_MEM_AW)-1];

	assign f_addr = frm[63:56];
	assign f_op   = frm[55:48];
	assign f_type = frm[47:40];
	assign f_val  = frm[31:0];
	assign evt_set = pos_reached_i && pend_q && !(move_to_position_cmd_i && arm_q);

	// Build a normal reply word
	function [63:0] reply;
		input [7:0]  st;
		input [7:0]  op;
		input [31:0] val;
		begin
			reply = {`MMC_HOST_ADDR, `MMC_MOD_ADDR, st, op, val};
		end
	endfunction

	// Control opcodes run directly even while downloading
	function is_ctrl;
		input [7:0] op;
		begin
			is_ctrl = (op >= `MMC_OP_STOP && op <= `MMC_OP_POSREQ) ||
				(op == `MMC_OP_SWRST);
		end
	endfunction

	// Release reset through two flops
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	// Frame assembly and checksum test
	mmc_rx u_rx (
		.clk_i       (clk_i),
		.rst_ni      (rst_n_q),
		.byte_i      (rx_byte_i),
		.valid_i     (rx_valid_i),
		.frm_valid_o (frm_valid),
		.frm_ok_o    (frm_ok),
		.frm_o       (frm)
	);

	// Reply serialiser
	mmc_tx u_tx (
		.clk_i   (clk_i),
		.rst_ni  (rst_n_q),
		.load_i  (tx_load_q),
		.data_i  (tx_data_q),
		.busy_o  (tx_busy),
		.byte_o  (tx_byte_o),
		.valid_o (tx_valid_o),
		.ready_i (tx_ready_i)
	);

	// Program memory write in download mode, engine read port
	// Memory has no reset, so contents are unknown until written
	always @(posedge clk_i) begin
		if (state_q == S_IDLE && frm_valid && frm_ok && f_addr == `MMC_MOD_ADDR &&
			download_o && !is_ctrl(f_op)) begin
			mem[memptr_q] <= frm[55:0];
		end
		mem_rd_data_o <= mem[mem_rd_addr_i];
	end

	// Command interpreter
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q           <= S_IDLE;
			mode_q            <= `MMC_MODE_STOP;
			memptr_q          <= 8'h00;
			arm_q             <= 1'b0;
			persist_q         <= 1'b0;
			mask_q            <= 8'h00;
			pend_q            <= 1'b0;
			evt_q             <= 1'b0;
			tx_load_q         <= 1'b0;
			tx_data_q         <= 64'h0;
			fwd_valid_o       <= 1'b0;
			fwd_op_o          <= 8'h00;
			fwd_type_o        <= 8'h00;
			fwd_bank_o        <= 8'h00;
			fwd_value_o       <= 32'h0;
			prog_run_o        <= 1'b0;
			prog_step_o       <= 1'b0;
			prog_jump_o       <= 1'b0;
			prog_addr_o       <= 16'h0;
			prog_clear_o      <= 1'b0;
			download_o        <= 1'b0;
			factory_restore_o <= 1'b0;
			sw_reset_o        <= 1'b0;
		end else begin
			// Pulses last one cycle
			tx_load_q         <= 1'b0;
			fwd_valid_o       <= 1'b0;
			prog_step_o       <= 1'b0;
			prog_jump_o       <= 1'b0;
			prog_clear_o      <= 1'b0;
			factory_restore_o <= 1'b0;
			sw_reset_o        <= 1'b0;

			// A single step ends once the engine reports it
			if (mode_q == `MMC_MODE_STEP && eng_step_done_i) begin
				mode_q <= `MMC_MODE_STOP;
			end

			// A move started while armed waits for arrival
			if (move_to_position_cmd_i && arm_q) begin
				pend_q <= 1'b1;
				if (!persist_q) begin
					arm_q <= 1'b0;
				end
			end else if (pos_reached_i && pend_q) begin
				pend_q <= 1'b0;
				evt_q  <= 1'b1;
			end

			case (state_q)
				S_IDLE: begin
					if (frm_valid && f_addr == `MMC_MOD_ADDR) begin
						state_q   <= S_SEND;
						tx_load_q <= 1'b1;
						tx_data_q <= reply(`MMC_ST_OK, f_op, 32'h0);
						if (!frm_ok) begin
							// Bad sum: nothing is acted on
							tx_data_q <= reply(`MMC_ST_BADSUM, f_op, 32'h0);
						end else if (download_o && !is_ctrl(f_op)) begin
							// Stored, acknowledged, not run
							memptr_q <= memptr_q + 8'h01;
						end else if (f_op == `MMC_OP_STOP) begin
							prog_run_o <= 1'b0;
							mode_q     <= `MMC_MODE_STOP;
						end else if (f_op == `MMC_OP_RUN) begin
							prog_run_o <= 1'b1;
							mode_q     <= `MMC_MODE_RUN;
							if (f_type[0]) begin
								prog_jump_o <= 1'b1;
								prog_addr_o <= f_val[15:0];
							end
						end else if (f_op == `MMC_OP_STEP) begin
							prog_run_o  <= 1'b0;
							prog_step_o <= 1'b1;
							mode_q      <= `MMC_MODE_STEP;
						end else if (f_op == `MMC_OP_PRST) begin
							prog_run_o   <= 1'b0;
							prog_clear_o <= 1'b1;
							mode_q       <= `MMC_MODE_STOP;
						end else if (f_op == `MMC_OP_DLIN) begin
							prog_run_o <= 1'b0;
							download_o <= 1'b1;
							memptr_q   <= f_val[7:0];
							mode_q     <= `MMC_MODE_DL;
						end else if (f_op == `MMC_OP_DLOUT) begin
							download_o <= 1'b0;
							mode_q     <= `MMC_MODE_STOP;
						end else if (f_op == `MMC_OP_RDMEM) begin
							// Reply carries the stored word after the host address
							tx_data_q <= {`MMC_HOST_ADDR, mem[f_val[7:0]]};
						end else if (f_op == `MMC_OP_STAT) begin
							if (f_type == 8'h00) begin
								tx_data_q <= reply(`MMC_ST_OK, f_op,
									{mode_q, 7'h00, eng_wait_i, 8'h00, memptr_q});
							end else if (f_type == 8'h01) begin
								tx_data_q <= reply(`MMC_ST_OK, f_op,
									{mode_q, 7'h00, eng_wait_i, eng_pc_i});
							end else if (f_type == 8'h02) begin
								tx_data_q <= reply(`MMC_ST_OK, f_op, eng_acc_i);
							end else if (f_type == 8'h03) begin
								tx_data_q <= reply(`MMC_ST_OK, f_op, eng_x_i);
							end else begin
								tx_data_q <= reply(`MMC_ST_BADVAL, f_op, 32'h0);
							end
						end else if (f_op == `MMC_OP_VER) begin
							if (f_type[0]) begin
								tx_data_q <= reply(`MMC_ST_OK, f_op, VER_BIN);
							end else begin
								tx_data_q <= {`MMC_HOST_ADDR, VER_STR};
							end
						end else if (f_op == `MMC_OP_FRST) begin
							if (f_val == `MMC_MAGIC) begin
								factory_restore_o <= 1'b1;
								tx_load_q         <= 1'b0;
								state_q           <= S_IDLE;
							end else begin
								tx_data_q <= reply(`MMC_ST_BADVAL, f_op, 32'h0);
							end
						end else if (f_op == `MMC_OP_SWRST) begin
							if (f_val == `MMC_MAGIC) begin
								// Reset fires at once; no reply is sent
								sw_reset_o <= 1'b1;
								tx_load_q  <= 1'b0;
								state_q    <= S_IDLE;
							end else begin
								tx_data_q <= reply(`MMC_ST_BADVAL, f_op, 32'h0);
							end
						end else if (f_op == `MMC_OP_POSREQ) begin
							// Never stored, even in download mode
							arm_q     <= 1'b1;
							persist_q <= f_type[0];
							mask_q    <= f_val[7:0];
							pend_q    <= 1'b0;
							tx_data_q <= reply(`MMC_ST_OK, f_op,
								{24'h000000, f_val[7:0]});
						end else begin
							// Everything else belongs to the motion side
							tx_load_q   <= 1'b0;
							fwd_valid_o <= 1'b1;
							fwd_op_o    <= f_op;
							fwd_type_o  <= f_type;
							fwd_bank_o  <= frm[39:32];
							fwd_value_o <= f_val;
							state_q     <= S_FWD;
						end
					end else if (evt_q && !tx_busy) begin
						// Arrival reply only between command replies
						evt_q     <= evt_set; // A fresh arrival is not lost to the clear
						tx_load_q <= 1'b1;
						tx_data_q <= reply(`MMC_ST_EVT, `MMC_OP_POSREQ,
							{24'h000000, mask_q});
						state_q   <= S_SEND;
					end
				end
				S_FWD: begin
					if (fwd_done_i) begin
						tx_load_q <= 1'b1;
						tx_data_q <= reply(fwd_status_i, fwd_op_o, fwd_value_i);
						state_q   <= S_SEND;
					end
				end
				S_SEND: begin
					// Busy rises the cycle after the load
					if (!tx_load_q && !tx_busy) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// file: design/mmc_rx.v
`timescale 1ns/1ps
`include "mmc_defs.vh"

module mmc_rx (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_ni,
	// Byte stream from the link
	input  wire [7:0]  byte_i,
	input  wire        valid_i,
	// Assembled frame
	output reg         frm_valid_o,
	output reg         frm_ok_o,
	output wire [63:0] frm_o
);

	reg [3:0]  cnt_q;  // Bytes taken so far
	reg [7:0]  sum_q;  // Running checksum
	reg [63:0] buf_q;  // Eight leading bytes, first byte on top

	assign frm_o = buf_q;

	// Collect nine bytes; the ninth is compared against the sum
	always @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			cnt_q       <= 4'h0;
			sum_q       <= 8'h00;
			buf_q       <= 64'h0;
			frm_valid_o <= 1'b0;
			frm_ok_o    <= 1'b0;
		end else begin
			frm_valid_o <= 1'b0;
			if (valid_i) begin
				if (cnt_q == `MMC_FRAME_LEN - 4'h1) begin
					frm_valid_o <= 1'b1;
					frm_ok_o    <= (sum_q == byte_i);
					cnt_q       <= 4'h0;
					sum_q       <= 8'h00;
				end else begin
					buf_q <= {buf_q[55:0], byte_i};
					sum_q <= sum_q + byte_i;
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

endmodule

// file: design/mmc_tx.v
`timescale 1ns/1ps
`include "mmc_defs.vh"

module mmc_tx (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_ni,
	// Reply load
	input  wire        load_i,
	input  wire [63:0] data_i,
	output wire        busy_o,
	// Byte stream to the link
	output reg  [7:0]  byte_o,
	output reg         valid_o,
	input  wire        ready_i
);

	reg [55:0] sh_q;   // Bytes still to send
	reg [7:0]  sum_q;  // Running checksum
	reg [3:0]  left_q; // Bytes left after the current one

	assign busy_o = valid_o;

	// Send eight bytes then their sum
	always @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			sh_q    <= 56'h0;
			sum_q   <= 8'h00;
			left_q  <= 4'h0;
			byte_o  <= 8'h00;
			valid_o <= 1'b0;
		end else if (!valid_o) begin
			if (load_i) begin
				byte_o  <= data_i[63:56];
				sh_q    <= data_i[55:0];
				sum_q   <= data_i[63:56];
				left_q  <= `MMC_FRAME_LEN - 4'h1;
				valid_o <= 1'b1;
			end
		end else if (ready_i) begin
			if (left_q == 4'h0) begin
				valid_o <= 1'b0;
			end else if (left_q == 4'h1) begin
				byte_o <= sum_q;
				left_q <= 4'h0;
			end else begin
				byte_o <= sh_q[55:48];
				sum_q  <= sum_q + sh_q[55:48];
				sh_q   <= {sh_q[47:0], 8'h00};
				left_q <= left_q - 4'h1;
			end
		end
	end

endmodule

// file: shared/mmc_defs.vh
`ifndef MMC_DEFS_VH
`define MMC_DEFS_VH

// Frame layout
`define MMC_FRAME_LEN   4'h9
`define MMC_MOD_ADDR    8'h01
`define MMC_HOST_ADDR   8'h02

// Reply status codes
`define MMC_ST_OK       8'h64
`define MMC_ST_EVT      8'h80
`define MMC_ST_BADSUM   8'h01
`define MMC_ST_BADVAL   8'h04

// Control opcodes
`define MMC_OP_STOP     8'h80
`define MMC_OP_RUN      8'h81
`define MMC_OP_STEP     8'h82
`define MMC_OP_PRST     8'h83
`define MMC_OP_DLIN     8'h84
`define MMC_OP_DLOUT    8'h85
`define MMC_OP_RDMEM    8'h86
`define MMC_OP_STAT     8'h87
`define MMC_OP_VER      8'h88
`define MMC_OP_FRST     8'h89
`define MMC_OP_POSREQ   8'h8a
`define MMC_OP_SWRST    8'hff

// Key value for destructive commands
`define MMC_MAGIC       32'h000004d2

// Program modes reported by the status opcode
`define MMC_MODE_STOP   8'h00
`define MMC_MODE_RUN    8'h01
`define MMC_MODE_STEP   8'h02
`define MMC_MODE_DL     8'h03

// Program memory address width
`define MMC_MEM_AW      8

`endif

// file: testbench/mmc_ctrl_sva.sv
`timescale 1ns/1ps
// Watches the reply stream and the program-control outputs of the interpreter
module mmc_ctrl_chk (
	input wire       clk_i,
	input wire       resetn_i,
	input wire [7:0] tx_byte_o,
	input wire       tx_valid_o,
	input wire       tx_ready_i,
	input wire       fwd_valid_o,
	input wire       prog_run_o,
	input wire       prog_step_o,
	input wire       prog_jump_o,
	input wire       prog_clear_o,
	input wire       download_o,
	input wire       factory_restore_o,
	input wire       sw_reset_o
);
	reg [3:0] cnt_q; // Accepted bytes of the current reply
	reg [7:0] sum_q; // Running sum of those bytes
	// Track reply position; a reply is always nine bytes, so wrap after the last
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 4'h0;
			sum_q <= 8'h00;
		end else if (tx_valid_o && tx_ready_i) begin
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			sum_q <= (cnt_q == 4'h8) ? 8'h00 : sum_q + tx_byte_o;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_accept;
		tx_valid_o && tx_ready_i;
	endsequence
	sequence s_last;
		s_accept ##0 (cnt_q == 4'h8);
	endsequence
	property p_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o);
	endproperty
	property p_head;
		tx_valid_o && cnt_q == 4'h0 |-> tx_byte_o == 8'h02;
	endproperty
	property p_sum;
		tx_valid_o && cnt_q == 4'h8 |-> tx_byte_o == sum_q;
	endproperty
	property p_end;
		s_last |=> !tx_valid_o;
	endproperty
	property p_frst;
		factory_restore_o |-> !tx_valid_o [*8];
	endproperty
	property p_swrst;
		sw_reset_o |-> !tx_valid_o [*8];
	endproperty
	property p_dl;
		download_o |-> !fwd_valid_o;
	endproperty
	property p_clear;
		prog_clear_o |=> !prog_run_o;
	endproperty
	property p_jump;
		prog_jump_o |-> ##[0:1] prog_run_o;
	endproperty
	property p_step;
		prog_step_o |=> !prog_step_o;
	endproperty
	a_hold: assert property (p_hold) else $error("reply byte changed while stalled");
	a_head: assert property (p_head) else $error("reply does not open with 02");
	a_sum: assert property (p_sum) else $error("reply checksum wrong");
	a_end: assert property (p_end) else $error("reply longer than nine bytes");
	a_frst: assert property (p_frst) else $error("reply after restore");
	a_swrst: assert property (p_swrst) else $error("reply after soft reset");
	a_dl: assert property (p_dl) else $error("command executed in download");
	a_clear: assert property (p_clear) else $error("program runs after clear");
	a_jump: assert property (p_jump) else $error("jump without run");
	a_step: assert property (p_step) else $error("step pulse too long");
endmodule
bind mmc_ctrl mmc_ctrl_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .tx_byte_o(tx_byte_o),
	.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .fwd_valid_o(fwd_valid_o),
	.prog_run_o(prog_run_o), .prog_step_o(prog_step_o), .prog_jump_o(prog_jump_o),
	.prog_clear_o(prog_clear_o), .download_o(download_o),
	.factory_restore_o(factory_restore_o), .sw_reset_o(sw_reset_o));

// file: testbench/mmc_host.sv
`timescale 1ns/1ps
// Host end of the command link: sends frames, gathers whole replies
module mmc_host (
	input  wire       clk_i,
	input  wire [7:0] tx_byte_i,
	input  wire       tx_valid_i,
	output reg  [7:0] rx_byte_o,
	output reg        rx_valid_o,
	output reg        tx_ready_o
);
	logic [71:0] replies[$]; // Complete replies, oldest first
	logic [71:0] acc_q;      // Reply being gathered
	int          n_q;        // Bytes gathered so far
	initial begin
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b0;
		n_q = 0;
	end
	// Stall at random so the device must hold each byte
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			acc_q = {acc_q[63:0], tx_byte_i};
			n_q = n_q + 1;
			if (n_q == 9) begin
				replies.push_back(acc_q);
				n_q = 0;
			end
		end
		#1 tx_ready_o = ($urandom % 3) != 0;
	end
	// One frame, a byte a cycle; a bad sum only when asked
	task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] v,
			input bit bad);
		logic [71:0] f;
		f = {8'h01, op, typ, 8'h00, v, 8'h00};
		for (int i = 1; i < 9; i++) f[7:0] = f[7:0] + f[8*i +: 8];
		if (bad) f[7:0] = ~f[7:0];
		for (int i = 8; i >= 0; i--) begin
			@(posedge clk_i);
			#1 rx_valid_o = 1'b1;
			rx_byte_o = f[8*i +: 8];
		end
		@(posedge clk_i);
		#1 rx_valid_o = 1'b0;
		rx_byte_o = ~rx_byte_o; // Idle line must not echo the last byte
	endtask
endmodule

// file: testbench/tb_motion_module_control_commands.sv
`timescale 1ns/1ps
`include "mmc_defs.vh"
module tb_motion_module_control_commands;
	localparam [55:0] VS = 56'h54455354303037; // Arbitrary version text
	localparam [31:0] VB = 32'h00020003;       // Arbitrary version number
	logic        clk_i, resetn_i, rx_valid, tx_valid, tx_ready, fwd_valid, fwd_done, mtp;
	logic        reached, step_done, run, step, jump, clr, dl, frst, swrst, waitf;
	logic [7:0]  rx_byte, tx_byte, fop, ftyp, fbank, mem_addr, op, t;
	logic [15:0] pc, paddr, ja;
	logic [31:0] acc, xr, fv, fval, v;
	logic [55:0] mem_data, fcap;
	logic [71:0] r, ev;
	bit          s_jump, s_step, s_clr, s_frst, s_swrst;
	int          errors, comparisons, nfwd;
	mmc_ctrl #(.VER_STR(VS), .VER_BIN(VB)) dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
		.tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.fwd_valid_o(fwd_valid), .fwd_op_o(fop), .fwd_type_o(ftyp), .fwd_bank_o(fbank),
		.fwd_value_o(fv), .fwd_done_i(fwd_done), .fwd_status_i(`MMC_ST_OK), .fwd_value_i(fval),
		.move_to_position_cmd_i(mtp), .pos_reached_i(reached), .prog_run_o(run),
		.prog_step_o(step), .prog_jump_o(jump), .prog_addr_o(paddr), .prog_clear_o(clr),
		.eng_pc_i(pc), .eng_wait_i(waitf), .eng_acc_i(acc), .eng_x_i(xr),
		.eng_step_done_i(step_done), .mem_rd_addr_i(mem_addr), .mem_rd_data_o(mem_data),
		.download_o(dl), .factory_restore_o(frst), .sw_reset_o(swrst));
	mmc_host host_u (.clk_i(clk_i), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
		.rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Motion side and engine answer a cycle after each request; pulses are noted
	always @(posedge clk_i) begin
		#1 fwd_done = fwd_valid;
		step_done = step;
		if (fwd_valid) begin
			fcap = {fop, ftyp, fbank, fv};
			nfwd++;
		end
		if (jump) begin
			s_jump = 1;
			ja = paddr;
		end
		s_step |= step;
		s_clr |= clr;
		s_frst |= frst;
		s_swrst |= swrst;
	end
	function automatic logic [71:0] fr(input logic [63:0] f);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) s = s + f[8*i +: 8];
		return {f, s};
	endfunction
	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic getr(output logic [71:0] g);
		int i;
		for (i = 0; i < 3000 && host_u.replies.size() == 0; i++) @(posedge clk_i);
		if (i == 3000) begin
			errors++;
			complete_run();
		end else g = host_u.replies.pop_front();
	endtask
	task automatic cmd(input logic [7:0] o, y, input logic [31:0] w, e);
		host_u.send(o, y, w, 1'b0);
		getr(r);
		chk("reply", fr({8'h02, 8'h01, `MMC_ST_OK, o, e}), r);
	endtask
	task automatic cmds(input logic [7:0] o, y, input logic [31:0] w, input bit bad,
			input logic [7:0] st);
		host_u.send(o, y, w, bad);
		getr(r);
		chk("status", st, r[55:48]);
		if (!bad) chk("opcode", o, r[47:40]);
	endtask
	task automatic quiet;
		repeat (60) @(posedge clk_i);
		chk("silence", 0, host_u.replies.size());
	endtask
	task automatic evt;
		@(posedge clk_i);
		#1 mtp = 1'b1;
		@(posedge clk_i);
		#1 mtp = 1'b0;
		repeat ($urandom % 20) @(posedge clk_i);
		#1 reached = 1'b1;
		@(posedge clk_i);
		#1 reached = 1'b0;
	endtask
	initial begin
		void'($urandom(32'h84393a86));
		resetn_i = 1'b0;
		{mtp, reached, fwd_done, step_done, mem_addr, fval} = '0;
		acc = $urandom;
		xr = $urandom;
		pc = $urandom;
		waitf = $urandom;
		ev = fr({8'h02, 8'h01, `MMC_ST_EVT, `MMC_OP_POSREQ, 32'h1});
		repeat (3) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		repeat (3) @(posedge clk_i);
		cmd(`MMC_OP_STAT, 8'h00, 0, {`MMC_MODE_STOP, 7'h0, waitf, 16'h0000});
		cmd(`MMC_OP_STAT, 8'h01, 0, {`MMC_MODE_STOP, 7'h0, waitf, pc});
		cmd(`MMC_OP_STAT, 8'h02, 0, acc);
		cmd(`MMC_OP_STAT, 8'h03, 0, xr);
		cmds(`MMC_OP_STAT, 8'h04, 0, 0, `MMC_ST_BADVAL);
		cmds(`MMC_OP_STAT, 8'h02, 0, 1, `MMC_ST_BADSUM);
		cmd(`MMC_OP_POSREQ, 8'h00, 1, 1);
		evt();
		evt();
		getr(r);
		chk("event", ev, r);
		quiet();
		cmd(`MMC_OP_POSREQ, 8'h01, 1, 1);
		repeat (2) begin
			evt();
			getr(r);
			chk("event", ev, r);
		end
		repeat (4) begin
			op = 8'h01 + 8'($urandom % 100);
			t = $urandom;
			v = $urandom;
			fval = $urandom;
			cmd(op, t, v, fval);
			chk("forward", {op, t, 8'h00, v}, fcap);
		end
		v = $urandom % 65536;
		cmds(`MMC_OP_RUN, 8'h01, v, 0, `MMC_ST_OK);
		chk("jump", {1'b1, v[15:0], 1'b1}, {s_jump, ja, run});
		cmds(`MMC_OP_STOP, 8'h00, 0, 0, `MMC_ST_OK);
		chk("stopped", 0, run);
		cmds(`MMC_OP_STEP, 8'h00, 0, 0, `MMC_ST_OK);
		chk("stepped", 1, s_step);
		cmds(`MMC_OP_RUN, 8'h00, 0, 0, `MMC_ST_OK);
		cmd(`MMC_OP_STAT, 8'h01, 0, {`MMC_MODE_RUN, 7'h0, waitf, pc});
		cmds(`MMC_OP_PRST, 8'h00, 0, 0, `MMC_ST_OK);
		chk("cleared", 2'b10, {s_clr, run});
		t = $urandom;
		cmds(`MMC_OP_DLIN, 8'h00, t, 0, `MMC_ST_OK);
		chk("download", 1, dl);
		v = $urandom;
		cmds(8'h05, 8'h02, v, 0, `MMC_ST_OK);
		#1 mem_addr = t;
		repeat (2) @(posedge clk_i);
		#1 chk("stored", {8'h05, 8'h02, 8'h00, v}, mem_data);
		cmd(`MMC_OP_STAT, 8'h00, 0, {`MMC_MODE_DL, 7'h0, waitf, 8'h00, t + 8'h01});
		cmds(`MMC_OP_DLOUT, 8'h00, 0, 0, `MMC_ST_OK);
		chk("download", 0, dl);
		host_u.send(`MMC_OP_RDMEM, 8'h00, t, 0);
		getr(r);
		chk("memory", fr({8'h02, 8'h05, 8'h02, 8'h00, v}), r);
		chk("forwards", 4, nfwd);
		cmd(`MMC_OP_VER, 8'h01, 0, VB);
		host_u.send(`MMC_OP_VER, 8'h00, 0, 0);
		getr(r);
		chk("version", fr({8'h02, VS}), r);
		cmds(`MMC_OP_FRST, 8'h00, 1233, 0, `MMC_ST_BADVAL);
		chk("restore", 0, s_frst);
		host_u.send(`MMC_OP_FRST, 8'h00, `MMC_MAGIC, 0);
		quiet();
		chk("restore", 1, s_frst);
		host_u.send(`MMC_OP_SWRST, 8'h00, `MMC_MAGIC, 0);
		quiet();
		chk("swreset", 1, s_swrst);
		complete_run();
	end
endmodule
